// ### dsadc_pkg.sv
// package for the dual-slope converter phase control ends
// assumes a single 125 MHz clock shared by both ends
package dsadc_pkg;

    // ****************************************
    // phase selects and timing
    // ****************************************
    typedef enum logic [1:0] {
        phase_zero,
        phase_input,
        phase_reference,
        phase_idle
    } phase_type;

    // select codes {first, second}
    localparam logic [1:0] SEL_ZERO = 2'h0;
    localparam logic [1:0] SEL_INPUT = 2'h3;
    localparam logic [1:0] SEL_REFERENCE = 2'h1;

    localparam int CLK_PERIOD_NS = 8;
    // default window lengths, in cycles (short, shortened by parameters)
    localparam int ZERO_CYCLES = 64;
    localparam int INPUT_CYCLES = 1000;
    localparam int REF_MAX_CYCLES = 2000;
    // comparator model: toggles each cycle while zeroing
    localparam int CNT_WIDTH = 24;
    // slowest conversion rate, 0.05 per second, gives 20 s
    localparam longint SLOWEST_CONV_NS = 64'd20000000000;
    // fastest rate, 20 per second, gives 50 ms
    localparam longint FASTEST_CONV_NS = 64'd50000000;
    localparam longint SLOWEST_CONV_CYCLES = SLOWEST_CONV_NS / CLK_PERIOD_NS;
    localparam longint FASTEST_CONV_CYCLES = FASTEST_CONV_NS / CLK_PERIOD_NS;

endpackage

// ### dsadc_if.sv
// interface joining the converter front end and its phase controller
// assumes both ends run on the same clock
interface dsadc_if;
    logic first_switch_code;
    logic second_switch_code;
    logic comparator_out;

    modport front_end (
        input first_switch_code,
        input second_switch_code,
        output comparator_out
    );

    modport controller (
        output first_switch_code,
        output second_switch_code,
        input comparator_out
    );
endinterface

// ### dsadc_front_end.sv
// digital model of the converter front end: switch decode and comparator
// assumes selects come from the controller on the shared clock
module dsadc_front_end
    import dsadc_pkg::*;
#(
    parameter int WIDTH = CNT_WIDTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // link
    dsadc_if.front_end link,
    // analog input and reference levels, as integer slopes
    input wire logic [WIDTH-1:0] input_level,
    input wire logic [WIDTH-1:0] reference_level,
    // switch state
    output logic zero_switches,
    output logic input_switch,
    output logic reference_switches
);

    logic [WIDTH+7:0] integrator;
    logic [WIDTH+7:0] next_integrator;
    logic comparator;
    logic next_comparator;

    // ****************************************
    // switch decode and integrator
    // ****************************************
    // decode selects and step the integrator
    always_comb begin
        next_integrator = integrator;
        next_comparator = comparator;
        zero_switches = 1'b0;
        input_switch = 1'b0;
        reference_switches = 1'b0;
        case ({link.first_switch_code, link.second_switch_code})
            SEL_ZERO: begin
                zero_switches = 1'b1;
                next_integrator = '0;
                next_comparator = ~comparator;
            end
            SEL_INPUT: begin
                input_switch = 1'b1;
                next_integrator = integrator + (WIDTH+8)'(input_level);
                next_comparator = 1'b0;
            end
            SEL_REFERENCE: begin
                reference_switches = 1'b1;
                if (integrator > (WIDTH+8)'(reference_level)) begin
                    next_integrator = integrator - (WIDTH+8)'(reference_level);
                    next_comparator = 1'b0;
                end else begin
                    next_integrator = '0;
                    next_comparator = 1'b1;
                end
            end
            default: begin
                next_comparator = 1'b0;
            end
        endcase
    end

    // register integrator and comparator
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            integrator <= '0;
            comparator <= 1'b0;
        end else begin
            integrator <= next_integrator;
            comparator <= next_comparator;
        end
    end

    assign link.comparator_out = comparator;

endmodule

// ### dsadc_controller.sv
// phase controller for the auto-zeroing dual-slope converter
// assumes the front end shares clk and answers on comparator_out
// assumes start is a level held until busy rises; it is not stored
// assumes CONV_SPACING fits in WIDTH bits
//
// Overview of operation
// - both selects low starts auto-zero
// - comparator toggles while zeroing, not a result
// - after zeroing, both selects high integrate input
// - after input window, first low second high
// - comparator rises when integrator reaches threshold
// - on comparator rise, return selects low
// - reading is reference time over input time
// - microcontroller conversion takes about 50 ms
// - conversion rate between 20 and 0.05 per second; only the 20 per second bound is enforced, via CONV_SPACING
module dsadc_controller
    import dsadc_pkg::*;
#(
    parameter int WIDTH = CNT_WIDTH,
    parameter int ZERO_LEN = ZERO_CYCLES,
    parameter int INPUT_LEN = INPUT_CYCLES,
    parameter int REF_MAX = REF_MAX_CYCLES,
    // shortest start-to-start spacing, in cycles
    parameter int CONV_SPACING = int'(FASTEST_CONV_CYCLES)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // link
    dsadc_if.controller link,
    // user side
    input wire logic start,
    output logic busy,
    output logic done,
    output logic timeout_error,
    output logic [WIDTH-1:0] reference_count,
    output logic [WIDTH-1:0] input_count
);

    // phase state
    phase_type phase;
    phase_type next_phase;
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic comp_prev;
    logic comp_rise;
    logic finish_good;
    logic finish_late;

    // result next values
    logic [WIDTH-1:0] next_reference_count;
    logic [WIDTH-1:0] next_input_count;
    logic next_done;
    logic next_timeout_error;

    // start spacing
    logic [WIDTH-1:0] since_start;
    logic [WIDTH-1:0] next_since_start;
    logic start_ok;
    logic accept;

    // ****************************************
    // start spacing
    // ****************************************
    // a start is taken only once the previous one is far enough back;
    // holding start longer simply delays the conversion
    assign start_ok = (since_start == WIDTH'(CONV_SPACING - 1));
    assign accept = (phase == phase_idle) & start & start_ok;

    // cycles since the last taken start, saturating at one less than the spacing
    always_comb begin
        next_since_start = since_start;
        if (accept) begin
            next_since_start = '0;
        end else if (!start_ok) begin
            next_since_start = since_start + WIDTH'(1);
        end
    end

    // register spacing count; reset leaves the first start free
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            since_start <= WIDTH'(CONV_SPACING - 1);
        end else begin
            since_start <= next_since_start;
        end
    end

    // ****************************************
    // phase sequencing
    // ****************************************
    // comparator edge, ignored outside the reference window
    assign comp_rise = link.comparator_out & ~comp_prev;
    // the two ways out of the reference window
    assign finish_good = (phase == phase_reference) & comp_rise;
    assign finish_late = (phase == phase_reference) & ~comp_rise
        & (count == WIDTH'(REF_MAX - 1));

    // next phase and window count
    always_comb begin
        next_phase = phase;
        next_count = count + WIDTH'(1);
        case (phase)
            phase_idle: begin
                next_count = '0;
                if (accept) begin
                    next_phase = phase_zero;
                end
            end
            phase_zero: begin
                // toggling comparator is not looked at here
                if (count == WIDTH'(ZERO_LEN - 1)) begin
                    next_phase = phase_input;
                    next_count = '0;
                end
            end
            phase_input: begin
                if (count == WIDTH'(INPUT_LEN - 1)) begin
                    next_phase = phase_reference;
                    next_count = '0;
                end
            end
            phase_reference: begin
                if (finish_good) begin
                    next_phase = phase_idle;
                end else if (finish_late) begin
                    next_phase = phase_idle;
                end
            end
            default: begin
                next_phase = phase_idle;
            end
        endcase
    end

    // register phase state
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phase <= phase_idle;
            count <= '0;
            comp_prev <= 1'b0;
        end else begin
            phase <= next_phase;
            count <= next_count;
            comp_prev <= link.comparator_out;
        end
    end

    // ****************************************
    // results
    // ****************************************
    // counts stand until the next comparator-ended done (a timeout done leaves them); error sticks until a start
    always_comb begin
        next_reference_count = reference_count;
        next_input_count = input_count;
        next_done = finish_good | finish_late;
        next_timeout_error = timeout_error;
        if (accept) begin
            next_timeout_error = 1'b0;
        end
        if (finish_good) begin
            next_reference_count = count + WIDTH'(1);
            next_input_count = WIDTH'(INPUT_LEN);
        end
        if (finish_late) begin
            next_timeout_error = 1'b1;
        end
    end

    // register results
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reference_count <= '0;
            input_count <= '0;
            done <= 1'b0;
            timeout_error <= 1'b0;
        end else begin
            reference_count <= next_reference_count;
            input_count <= next_input_count;
            done <= next_done;
            timeout_error <= next_timeout_error;
        end
    end

    // ****************************************
    // select drive
    // ****************************************
    // idle parks in auto-zero, selects both low
    // code 2'h2 is never driven; the front end opens all switches, holds the integrator and clears the comparator
    always_comb begin
        case (phase)
            phase_input: begin
                {link.first_switch_code, link.second_switch_code} = SEL_INPUT;
            end
            phase_reference: begin
                {link.first_switch_code, link.second_switch_code} = SEL_REFERENCE;
            end
            default: begin
                {link.first_switch_code, link.second_switch_code} = SEL_ZERO;
            end
        endcase
    end

    // busy while any phase runs
    assign busy = (phase != phase_idle);

endmodule

// ### dsadc_check_sva.sv
// checker for the select and comparator lines of the converter link
// assumes one clock domain and the link signals as plain inputs
module dsadc_check #(
    parameter int ZERO_LEN = 4,
    parameter int INPUT_LEN = 16,
    parameter int REF_MAX = 40
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // link
    input wire logic first_switch_code,
    input wire logic second_switch_code,
    input wire logic comparator_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] sel;
    logic [7:0] cnt_zero, cnt_in, cnt_ref, next_zero, next_in, next_ref;
    assign sel = {first_switch_code, second_switch_code};
    // ****************************************
    // run length of select codes 0, 3 and 1
    // ****************************************
    always_comb begin
        next_zero = (sel != 2'h0) ? 8'h0 : (cnt_zero == 8'hFF) ? cnt_zero : cnt_zero + 8'h1;
        next_in = (sel == 2'h3) ? cnt_in + 8'h1 : 8'h0;
        next_ref = (sel == 2'h1) ? cnt_ref + 8'h1 : 8'h0;
    end
    always_ff @(posedge clk) begin
        cnt_zero <= rst_b ? next_zero : 8'h0;
        cnt_in <= rst_b ? next_in : 8'h0;
        cnt_ref <= rst_b ? next_ref : 8'h0;
    end
    // ****************************************
    // phase order and lengths
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_legal_sel_code: assert property (sel != 2'h2) else $error("select code 2 seen");
    a_input_after_zero: assert property (sel == 2'h3 && $past(sel) != 2'h3
        |-> $past(sel) == 2'h0 && cnt_zero >= ZERO_LEN) else $error("input entry bad");
    a_input_length: assert property ($past(sel) == 2'h3 && sel != 2'h3
        |-> sel == 2'h1 && cnt_in == INPUT_LEN) else $error("input length bad");
    a_ref_after_input: assert property (sel == 2'h1 && $past(sel) != 2'h1
        |-> $past(sel) == 2'h3) else $error("reference entry bad");
    a_ref_to_zero: assert property ($past(sel) == 2'h1 && sel != 2'h1
        |-> sel == 2'h0) else $error("reference exit bad");
    a_cmp_ends_ref: assert property (sel == 2'h1 && comparator_out
        |=> sel == 2'h0) else $error("reference not ended");
    a_ref_bounded: assert property (sel == 2'h1 |-> cnt_ref <= REF_MAX)
        else $error("reference too long");
    a_zero_toggles: assert property (sel == 2'h0 && cnt_zero >= 3
        |-> comparator_out != $past(comparator_out)) else $error("no toggle");
    c_good: cover property ($past(sel) == 2'h1 && sel == 2'h0 && $past(comparator_out));
    c_late: cover property ($past(sel) == 2'h1 && sel == 2'h0 && !$past(comparator_out));
    c_input: cover property (sel == 2'h3);
endmodule

// ### tb_top.sv
// testbench for the phase controller facing the front end over the link
// assumes package, interface, design ends and checker compiled first
module tb_top import dsadc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = CNT_WIDTH;
    localparam int IL = 16;
    localparam int SP = 100;
    int cyc = 0;
    int last_acc = 0;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic start = 1'b0;
    logic busy, done, timeout_error, zero_sw, in_sw, ref_sw;
    logic [W-1:0] in_lvl = '0, ref_lvl = '0, ref_cnt, in_cnt;
    int error_cnt = 0;
    int checks = 0;
    // ****************************************
    // design ends, link and checker
    // ****************************************
    dsadc_if dsadc_if_i ();
    dsadc_controller #(.ZERO_LEN(4), .INPUT_LEN(IL), .REF_MAX(40), .CONV_SPACING(SP))
        dsadc_controller_i (.clk(clk),
        .rst_b(rst_b), .link(dsadc_if_i.controller), .start(start), .busy(busy), .done(done),
        .timeout_error(timeout_error), .reference_count(ref_cnt), .input_count(in_cnt));
    dsadc_front_end dsadc_front_end_i (.clk(clk), .rst_b(rst_b), .link(dsadc_if_i.front_end),
        .input_level(in_lvl), .reference_level(ref_lvl), .zero_switches(zero_sw),
        .input_switch(in_sw), .reference_switches(ref_sw));
    dsadc_check #(.ZERO_LEN(4), .INPUT_LEN(IL), .REF_MAX(40)) dsadc_check_i (.clk(clk),
        .rst_b(rst_b), .first_switch_code(dsadc_if_i.first_switch_code),
        .second_switch_code(dsadc_if_i.second_switch_code),
        .comparator_out(dsadc_if_i.comparator_out));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one conversion, start held until busy rises, phases sampled mid-way
    task automatic run(input logic [W-1:0] vi, input logic [W-1:0] vr, input logic to,
        input int gap);
        int n;
        @(posedge clk);
        in_lvl <= vi;
        ref_lvl <= vr;
        start <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (busy !== 1'b1 && n < 300);
        if (gap > 0) chk("spacing", gap, cyc - last_acc);
        last_acc = cyc;
        @(posedge clk);
        start <= 1'b0;
        @(negedge clk);
        chk("zero phase", 4'hC, {busy, zero_sw, in_sw, ref_sw});
        repeat (13) @(negedge clk);
        chk("input phase", 4'hA, {busy, zero_sw, in_sw, ref_sw});
        repeat (8) @(negedge clk);
        chk("ref phase", 4'h9, {busy, zero_sw, in_sw, ref_sw});
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk("finished", 1, n < 200);
        chk("done pulse", 1, done);
        chk("selects", 0, {dsadc_if_i.first_switch_code, dsadc_if_i.second_switch_code});
        chk("timeout", to, timeout_error);
        @(negedge clk);
        chk("done drop", 0, done);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_timeout();
        run(5, 1, 1'b1, 0);
        repeat (5) @(negedge clk);
        chk("sticky", 1, timeout_error);
        $display("test timeout done");
    endtask
    task automatic t_ratio();
        int vi[3] = '{1, 3, 2};
        int vr[3] = '{1, 2, 1};
        int e;
        for (int k = 0; k < 3; k++) begin
            run(vi[k], vr[k], 1'b0, SP);
            e = IL * vi[k] / vr[k];
            chk("input count", IL, in_cnt);
            chk("ratio", 1, ref_cnt + 2 >= e && ref_cnt <= e + 2);
        end
        $display("test ratio done");
    endtask
    // ****************************************
    // clock, reset, sequence and watchdog
    // ****************************************
    initial forever #4 clk = ~clk;
    // edge count for start spacing
    always @(posedge clk) cyc <= cyc + 1;
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_timeout();
        t_ratio();
        results();
    end
    initial begin
        #40000;
        error_cnt++;
        results();
    end
endmodule
